// ==== hdl/fmec_top.sv ====
// Top of the flash mode and erase control: strap capture, sequencer, loader.
// Assumes mode and protect pins are held through reset; single mclk domain.
`timescale 1ns/100ps
`default_nettype none
`include "fmec_defs.svh"
module fmec_top (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        reset_n,
  // Mode straps and serial pins
  input  wire logic [2:0]                  md_pin,
  input  wire logic                        program_erase_protect_pin,
  input  wire logic                        rxd_pin,
  output logic                             txd_pin,
  // Mode status
  output fmec_pkg::fmec_mode_t             flash_mode,
  output logic                             loader_active,
  output logic                             boot_done,
  // Page buffer load
  input  wire logic                        pb_wr,
  input  wire logic [`FMEC_PAGE_AW-1:0]    pb_idx,
  input  wire logic [7:0]                  pb_data,
  // Program and erase requests
  input  wire logic                        prog_req,
  input  wire logic [`FMEC_AW-1:0]         prog_addr,
  input  wire logic                        erase_req,
  input  wire logic                        erase_all,
  input  wire logic [`FMEC_BLK_W-1:0]      erase_blk,
  output logic                             busy,
  output logic                             done,
  output logic                             refused,
  // Flash array write port
  output logic                             arr_wr,
  output logic [`FMEC_AW-1:0]              arr_addr,
  output logic [7:0]                       arr_wdata,
  // Loader RAM write port
  output logic                             ram_wr,
  output logic [`FMEC_RAM_AW-1:0]          ram_addr,
  output logic [7:0]                       ram_wdata
);
  import fmec_pkg::*;

  function automatic logic [`FMEC_AW-1:0] blk_last(
    input logic [`FMEC_BLK_W-1:0] b);
    unique case (b)
      4'h0:    blk_last = `FMEC_BLK0_LAST;
      4'h1:    blk_last = `FMEC_BLK1_LAST;
      4'h2:    blk_last = `FMEC_BLK2_LAST;
      4'h3:    blk_last = `FMEC_BLK3_LAST;
      4'h4:    blk_last = `FMEC_BLK4_LAST;
      4'h5:    blk_last = `FMEC_BLK5_LAST;
      4'h6:    blk_last = `FMEC_BLK6_LAST;
      4'h7:    blk_last = `FMEC_BLK7_LAST;
      4'h8:    blk_last = `FMEC_BLK8_LAST;
      default: blk_last = `FMEC_BLK9_LAST;
    endcase
  endfunction

  function automatic logic [`FMEC_AW-1:0] blk_first(
    input logic [`FMEC_BLK_W-1:0] b);
    if (b == 4'h0)
      blk_first = `FMEC_ARR_FIRST;
    else
      blk_first = blk_last(b - 4'h1) + 17'h00001;
  endfunction

  // Pin synchronisers
  logic [2:0]  md_s1, md_s2;
  logic        fwe_s1, fwe_s2, rx_s1, rx_s2;

  always_ff @(posedge mclk) begin
    md_s1  <= md_pin;
    md_s2  <= md_s1;
    fwe_s1 <= program_erase_protect_pin;
    fwe_s2 <= fwe_s1;
    rx_s1  <= rxd_pin;
    rx_s2  <= rx_s1;
  end

  // Strap capture and program/erase sequencer
  fmec_mode_t              mode_r, mode_nxt;
  logic                    strap_r, strap_nxt;
  fmec_seq_t               st_r, st_nxt;
  logic [`FMEC_AW-1:0]     addr_r, addr_nxt;
  logic [`FMEC_AW-1:0]     last_r, last_nxt;
  logic                    wr_r, wr_nxt;
  logic [7:0]              wd_r, wd_nxt;
  logic                    done_r, done_nxt;
  logic                    ref_r, ref_nxt;
  logic [7:0]              page_mem [`FMEC_PAGE_BYTES];
  logic                    pe_mode, may_prog, may_erase;

  assign flash_mode = mode_r;
  assign arr_wr     = wr_r;
  assign arr_addr   = addr_r;
  assign arr_wdata  = wd_r;
  assign done       = done_r;
  assign refused    = ref_r;
  assign busy       = (st_r != S_IDLE);

  assign pe_mode   = strap_r && fwe_s2 && mode_r != FMEC_USER;
  assign may_prog  = pe_mode && prog_addr[`FMEC_PAGE_AW-1:0] == 7'h00;
  assign may_erase = pe_mode && (erase_all || (mode_r != FMEC_BOOT
                     && erase_blk < `FMEC_NBLK));

  always_ff @(posedge mclk) begin
    if (pb_wr)
      page_mem[pb_idx] <= pb_data;
  end

  always_comb begin
    mode_nxt  = mode_r;
    strap_nxt = 1'b1;
    st_nxt    = st_r;
    addr_nxt  = addr_r;
    last_nxt  = last_r;
    wr_nxt    = 1'b0;
    wd_nxt    = wd_r;
    done_nxt  = 1'b0;
    ref_nxt   = 1'b0;
    // Mode fixed once, in the first cycle after reset release
    if (!strap_r) begin
      if (!fwe_s2)
        mode_nxt = FMEC_USER;
      else if (md_s2 == `FMEC_MD_PROGRAMMER)
        mode_nxt = FMEC_PROGRAMMER;
      else if (md_s2 == `FMEC_MD_BOOT)
        mode_nxt = FMEC_BOOT;
      else
        mode_nxt = FMEC_USER_PROG;
    end
    unique case (st_r)
      S_IDLE: begin
        if (erase_req) begin
          if (may_erase) begin
            st_nxt   = S_ERASE;
            addr_nxt = erase_all ? `FMEC_ARR_FIRST : blk_first(erase_blk);
            last_nxt = erase_all ? `FMEC_BLK9_LAST : blk_last(erase_blk);
          end else
            ref_nxt = 1'b1;
        end else if (prog_req) begin
          if (may_prog) begin
            st_nxt   = S_PROG;
            addr_nxt = prog_addr - 17'h00001;
            last_nxt = prog_addr + 17'h0007f;
          end else
            ref_nxt = 1'b1;
        end
      end
      S_ERASE: begin
        // One byte per cycle, whole block
        wr_nxt = 1'b1;
        wd_nxt = `FMEC_ERASED;
        if (wr_r)
          addr_nxt = addr_r + 17'h00001;
        if (wr_r && addr_r == last_r - 17'h00001) begin
          st_nxt = S_IDLE;
          done_nxt = 1'b1;
        end
      end
      S_PROG: begin
        wr_nxt   = 1'b1;
        addr_nxt = addr_r + 17'h00001;
        wd_nxt   = page_mem[addr_nxt[`FMEC_PAGE_AW-1:0]];
        if (addr_nxt == last_r) begin
          st_nxt   = S_IDLE;
          done_nxt = 1'b1;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mode_r  <= FMEC_USER;
      strap_r <= 1'b0;
      st_r    <= S_IDLE;
      addr_r  <= `FMEC_ARR_FIRST;
      last_r  <= `FMEC_ARR_FIRST;
      wr_r    <= 1'b0;
      wd_r    <= `FMEC_ERASED;
      done_r  <= 1'b0;
      ref_r   <= 1'b0;
    end else begin
      mode_r  <= mode_nxt;
      strap_r <= strap_nxt;
      st_r    <= st_nxt;
      addr_r  <= addr_nxt;
      last_r  <= last_nxt;
      wr_r    <= wr_nxt;
      wd_r    <= wd_nxt;
      done_r  <= done_nxt;
      ref_r   <= ref_nxt;
    end
  end

  // Boot loader: length high, length low, then that many bytes to RAM
  fmec_ldr_t               ld_r, ld_nxt;
  logic [15:0]             len_r, len_nxt;
  logic [`FMEC_RAM_AW-1:0] ra_r, ra_nxt;
  logic                    rw_r, rw_nxt;
  logic [7:0]              rd_r, rd_nxt;
  logic                    b_lock, b_vld;
  logic [7:0]              b_data;

  assign loader_active = (ld_r != L_IDLE) && (ld_r != L_DONE);
  assign boot_done     = (ld_r == L_DONE);
  assign ram_wr        = rw_r;
  assign ram_addr      = ra_r;
  assign ram_wdata     = rd_r;

  fmec_baud u_baud (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .enable    (loader_active),
    .rxd       (rx_s2),
    .txd       (txd_pin),
    .locked    (b_lock),
    .byte_vld  (b_vld),
    .byte_data (b_data)
  );

  always_comb begin
    ld_nxt  = ld_r;
    len_nxt = len_r;
    ra_nxt  = ra_r;
    rw_nxt  = 1'b0;
    rd_nxt  = rd_r;
    unique case (ld_r)
      L_IDLE:
        if (strap_r && mode_r == FMEC_BOOT)
          ld_nxt = L_SYNC;
      L_SYNC:
        if (b_lock)
          ld_nxt = L_LEN_HI;
      L_LEN_HI:
        if (b_vld) begin
          len_nxt = {b_data, 8'h00};
          ld_nxt  = L_LEN_LO;
        end
      L_LEN_LO:
        if (b_vld) begin
          len_nxt = {len_r[15:8], b_data};
          ld_nxt  = ({len_r[15:8], b_data} == 16'h0000) ? L_DONE : L_DATA;
        end
      L_DATA:
        if (b_vld) begin
          rw_nxt  = 1'b1;
          rd_nxt  = b_data;
          len_nxt = len_r - 16'h0001;
          if (len_r == 16'h0001)
            ld_nxt = L_DONE;
        end
      L_DONE: ld_nxt = L_DONE;
      default: ld_nxt = L_IDLE;
    endcase
    if (rw_r)
      ra_nxt = ra_r + 12'h001;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ld_r  <= L_IDLE;
      len_r <= 16'h0000;
      ra_r  <= 12'h000;
      rw_r  <= 1'b0;
      rd_r  <= 8'h00;
    end else begin
      ld_r  <= ld_nxt;
      len_r <= len_nxt;
      ra_r  <= ra_nxt;
      rw_r  <= rw_nxt;
      rd_r  <= rd_nxt;
    end
  end

  // Checks
  logic [8:0] nwr_r;
  always_ff @(posedge mclk) begin
    if (!reset_n || st_r == S_IDLE)
      nwr_r <= 9'h000;
    else if (wr_r)
      nwr_r <= nwr_r + 9'h001;
  end

  prog_unit_a: assert property (@(posedge mclk) disable iff (!reset_n)
    st_r == S_PROG && st_nxt == S_IDLE |-> nwr_r == 9'h07e && wr_r)
    else $error("program unit is not 128 bytes");

  prog_align_a: assert property (@(posedge mclk) disable iff (!reset_n)
    st_r == S_IDLE && st_nxt == S_PROG |-> prog_addr[6:0] == 7'h00)
    else $error("program started on unaligned address");

  erase_ones_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(st_r) == S_ERASE && wr_r |-> arr_wdata == 8'hff)
    else $error("erase wrote a value other than all ones");

  blk_bound_a: assert property (@(posedge mclk) disable iff (!reset_n)
    st_r == S_ERASE && wr_r |-> addr_r <= last_r)
    else $error("erase ran past its block");

  user_refuse_a: assert property (@(posedge mclk) disable iff (!reset_n)
    strap_r && mode_r == FMEC_USER && st_r == S_IDLE
    && (prog_req || erase_req) |=> refused ##1 !arr_wr)
    else $error("user mode accepted a program or erase");

  boot_noblk_a: assert property (@(posedge mclk) disable iff (!reset_n)
    mode_r == FMEC_BOOT && st_r == S_IDLE && erase_req && !erase_all
    |=> refused && st_r == S_IDLE)
    else $error("boot mode accepted a block erase");

  mode_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    strap_r |=> $stable(flash_mode))
    else $error("mode changed after reset release");

  loader_go_a: assert property (@(posedge mclk) disable iff (!reset_n)
    strap_r && mode_r == FMEC_BOOT && ld_r == L_IDLE |=> loader_active)
    else $error("loader did not start in boot mode");

  pgmr_take_a: assert property (@(posedge mclk) disable iff (!reset_n)
    mode_r == FMEC_PROGRAMMER && fwe_s2 && st_r == S_IDLE && erase_req
    && erase_all |=> st_r == S_ERASE && !refused)
    else $error("programmer mode refused a total erase");

  idle_quiet_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !pe_mode && st_r == S_IDLE |=> !arr_wr)
    else $error("array written outside a program-capable mode");

endmodule
`default_nettype wire

// ==== hdl/fmec_defs.svh ====
// Constants for the flash mode and erase control block.
// Assumes a 128 kbyte array, byte wide, and a 4 kbyte RAM for the loader.
`ifndef FMEC_DEFS_SVH
`define FMEC_DEFS_SVH

`define FMEC_AW          17
`define FMEC_PAGE_BYTES  128
`define FMEC_PAGE_AW     7
`define FMEC_ERASED      8'hff
`define FMEC_NBLK        4'ha
`define FMEC_BLK_W       4
`define FMEC_RAM_AW      12

// Mode pin codes
`define FMEC_MD_PROGRAMMER 3'h0
`define FMEC_MD_BOOT       3'h3

// Last address of each erase block (1k x4, 8k x2, 16k, 28k, 32k x2)
`define FMEC_BLK0_LAST  17'h003ff
`define FMEC_BLK1_LAST  17'h007ff
`define FMEC_BLK2_LAST  17'h00bff
`define FMEC_BLK3_LAST  17'h00fff
`define FMEC_BLK4_LAST  17'h02fff
`define FMEC_BLK5_LAST  17'h04fff
`define FMEC_BLK6_LAST  17'h08fff
`define FMEC_BLK7_LAST  17'h0ffff
`define FMEC_BLK8_LAST  17'h17fff
`define FMEC_BLK9_LAST  17'h1ffff
`define FMEC_ARR_FIRST  17'h00000

// Serial loader
`define FMEC_CW          16
`define FMEC_SYNC_BITS   16'h0009
`define FMEC_ACK_BYTE    8'h00
`define FMEC_FRAME_BITS  4'h9

`endif

// ==== hdl/fmec_pkg.sv ====
// Types shared by the flash mode and erase control files.
// Assumes fmec_defs.svh is on the include path.
package fmec_pkg;
  typedef enum logic [1:0] {
    FMEC_USER, FMEC_BOOT, FMEC_USER_PROG, FMEC_PROGRAMMER
  } fmec_mode_t;
  typedef enum logic [1:0] {S_IDLE, S_ERASE, S_PROG} fmec_seq_t;
  typedef enum logic [2:0] {
    L_IDLE, L_SYNC, L_LEN_HI, L_LEN_LO, L_DATA, L_DONE
  } fmec_ldr_t;
  typedef enum logic [2:0] {
    B_WAIT, B_MEAS, B_ACK, B_IDLE, B_RX
  } fmec_baud_t;
endpackage

// ==== hdl/fmec_baud.sv ====
// Serial port of the boot loader: bit-rate measurement, byte receive, ack.
// Assumes rxd is already synchronised to mclk; host sends 8'h00 to sync.
`timescale 1ns/100ps
`default_nettype none
`include "fmec_defs.svh"
module fmec_baud (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               reset_n,
  // Control
  input  wire logic               enable,
  // Serial lines
  input  wire logic               rxd,
  output logic                    txd,
  // Received bytes
  output logic                    locked,
  output logic                    byte_vld,
  output logic [7:0]              byte_data
);
  import fmec_pkg::*;

  fmec_baud_t       st_r, st_nxt;
  logic [15:0]      cnt_r, cnt_nxt;
  logic [15:0]      per_r, per_nxt;
  logic [3:0]       bit_r, bit_nxt;
  logic [9:0]       sh_r, sh_nxt;
  logic             lock_r, lock_nxt;
  logic             vld_r, vld_nxt;
  logic [7:0]       dat_r, dat_nxt;
  logic             txd_r, txd_nxt;
  logic             rx_q;

  assign locked    = lock_r;
  assign byte_vld  = vld_r;
  assign byte_data = dat_r;
  assign txd       = txd_r;

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r + 16'h0001;
    per_nxt  = per_r;
    bit_nxt  = bit_r;
    sh_nxt   = sh_r;
    lock_nxt = lock_r;
    vld_nxt  = 1'b0;
    dat_nxt  = dat_r;
    txd_nxt  = txd_r;
    unique case (st_r)
      B_WAIT: begin
        cnt_nxt = 16'h0001;
        if (enable && rx_q && !rxd)
          st_nxt = B_MEAS;
      end
      B_MEAS: begin
        // Start bit plus eight zero bits form one long low pulse
        if (rxd) begin
          per_nxt  = cnt_r / `FMEC_SYNC_BITS;
          lock_nxt = 1'b1;
          st_nxt   = B_ACK;
          cnt_nxt  = 16'h0000;
          bit_nxt  = 4'h0;
          sh_nxt   = {1'b1, `FMEC_ACK_BYTE, 1'b0};
        end
      end
      B_ACK: begin
        // Ack sent at the measured rate
        txd_nxt = sh_r[0];
        if (cnt_r >= per_r - 16'h0001) begin
          cnt_nxt = 16'h0000;
          sh_nxt  = {1'b1, sh_r[9:1]};
          bit_nxt = bit_r + 4'h1;
          if (bit_r == `FMEC_FRAME_BITS)
            st_nxt = B_IDLE;
        end
      end
      B_IDLE: begin
        txd_nxt = 1'b1;
        cnt_nxt = 16'h0000;
        bit_nxt = 4'h0;
        if (rx_q && !rxd)
          st_nxt = B_RX;
      end
      B_RX: begin
        // Sample each bit mid-period
        if (cnt_r == {1'b0, per_r[15:1]} + per_r * {12'h000, bit_r}) begin
          if (bit_r != 4'h0)
            dat_nxt = {rxd, dat_r[7:1]};
          bit_nxt = bit_r + 4'h1;
          if (bit_r == 4'h8) begin
            vld_nxt = 1'b1;
            st_nxt  = B_IDLE;
          end
        end
      end
      default: st_nxt = B_WAIT;
    endcase
  end

  always_ff @(posedge mclk) begin
    rx_q <= rxd;
    if (!reset_n) begin
      st_r   <= B_WAIT;
      cnt_r  <= 16'h0000;
      per_r  <= 16'h0000;
      bit_r  <= 4'h0;
      sh_r   <= 10'h3ff;
      lock_r <= 1'b0;
      vld_r  <= 1'b0;
      dat_r  <= 8'h00;
      txd_r  <= 1'b1;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      per_r  <= per_nxt;
      bit_r  <= bit_nxt;
      sh_r   <= sh_nxt;
      lock_r <= lock_nxt;
      vld_r  <= vld_nxt;
      dat_r  <= dat_nxt;
      txd_r  <= txd_nxt;
    end
  end

  rate_match_a: assert property (@(posedge mclk) disable iff (!reset_n)
    st_r == B_MEAS && rxd |=> locked && per_r == $past(cnt_r) / 16'h0009)
    else $error("measured bit period not taken");

endmodule
`default_nettype wire

// ==== testbench/fmec_host.sv ====
// Boot host model: sends the sync frame, times the ack, then the program.
// Assumes the device answers the sync with an all-zero ack byte on txd.
`timescale 1ns/100ps
`default_nettype none
module fmec_host #(
  parameter int          BIT_CYC = 16,
  parameter logic [23:0] PAYLOAD = 24'h3ca75a
) (
  // Clock and trigger
  input  wire logic        mclk,
  input  wire logic        go,
  // Serial lines
  input  wire logic        txd,
  output logic             rxd,
  // Measured ack low time
  output logic [15:0]      ack_low
);
  localparam int NB = 3;

  task automatic send_byte(input logic [7:0] b);
    rxd <= 1'b0;
    repeat (BIT_CYC) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      rxd <= b[i];
      repeat (BIT_CYC) @(posedge mclk);
    end
    rxd <= 1'b1;
    repeat (BIT_CYC) @(posedge mclk);
  endtask

  initial begin
    rxd = 1'b1;
    ack_low = '0;
    forever begin
      @(posedge mclk);
      if (go === 1'b1) begin
        // Sync frame: start plus eight zero bits
        rxd <= 1'b0;
        repeat (9 * BIT_CYC) @(posedge mclk);
        rxd <= 1'b1;
        for (int i = 0; i < 4000 && txd !== 1'b0; i++) @(posedge mclk);
        while (txd === 1'b0 && ack_low < 16'hffff) begin
          ack_low++;
          @(posedge mclk);
        end
        // Let the stop bit of the ack and two more bit times pass
        repeat (3 * BIT_CYC) @(posedge mclk);
        send_byte(8'h00);
        send_byte(8'(NB));
        for (int i = 0; i < NB; i++) send_byte(PAYLOAD[8*i +: 8]);
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb_fmec_top.sv ====
// Self-checking bench for the flash mode and erase control top.
// Assumes fmec_host stands on the serial pins as the boot host.
`timescale 1ns/100ps
`default_nettype none
`include "fmec_defs.svh"
module tb_fmec_top;
  import fmec_pkg::*;
  localparam int          BIT_CYC = 16;
  localparam logic [23:0] PAYLOAD = 24'h3ca75a;
  logic        mclk, reset_n, program_erase_protect_pin, rxd_pin, txd_pin;
  logic        loader_active, boot_done, pb_wr, prog_req, erase_req;
  logic        erase_all, busy, done, refused, arr_wr, ram_wr, go;
  logic [2:0]  md_pin;
  fmec_mode_t  flash_mode;
  logic [6:0]  pb_idx;
  logic [7:0]  pb_data, arr_wdata, ram_wdata;
  logic [16:0] prog_addr, arr_addr;
  logic [3:0]  erase_blk;
  logic [11:0] ram_addr;
  logic [15:0] ack_low;
  int          n_mismatch, samples_checked;
  int          blk_size [10] = '{1024, 1024, 1024, 1024, 8192, 8192,
                                 16384, 28672, 32768, 32768};

  fmec_top fmec_top_inst (
    .mclk(mclk), .reset_n(reset_n), .md_pin(md_pin),
    .program_erase_protect_pin(program_erase_protect_pin),
    .rxd_pin(rxd_pin), .txd_pin(txd_pin), .flash_mode(flash_mode),
    .loader_active(loader_active), .boot_done(boot_done),
    .pb_wr(pb_wr), .pb_idx(pb_idx), .pb_data(pb_data),
    .prog_req(prog_req), .prog_addr(prog_addr), .erase_req(erase_req),
    .erase_all(erase_all), .erase_blk(erase_blk), .busy(busy),
    .done(done), .refused(refused), .arr_wr(arr_wr),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata), .ram_wr(ram_wr),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata)
  );

  fmec_host #(.BIT_CYC(BIT_CYC), .PAYLOAD(PAYLOAD)) fmec_host_inst (
    .mclk(mclk), .go(go), .txd(txd_pin), .rxd(rxd_pin), .ack_low(ack_low)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic complete_run();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] pat(input int i);
    return i[7:0] ^ 8'h5c;
  endfunction

  // Straps set during reset, held 3 edges, released
  task automatic do_reset(input logic [2:0] md, input logic pe);
    @(posedge mclk);
    reset_n <= 1'b0;
    md_pin <= md;
    program_erase_protect_pin <= pe;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic request(input logic prg, input logic all,
                         input logic [3:0] blk, input logic [16:0] a);
    @(posedge mclk);
    prog_req <= prg;
    erase_req <= !prg;
    erase_all <= all;
    erase_blk <= blk;
    prog_addr <= a;
    @(posedge mclk);
    prog_req <= 1'b0;
    erase_req <= 1'b0;
  endtask

  task automatic expect_refused();
    int hits;
    int wr;
    hits = 0;
    wr = 0;
    repeat (4) begin
      #1;
      hits += (refused === 1'b1);
      wr += (arr_wr === 1'b1);
      @(posedge mclk);
    end
    chk(hits, 1);
    chk(wr, 0);
  endtask

  task automatic load_page();
    for (int i = 0; i < 128; i++) begin
      @(posedge mclk);
      pb_wr <= 1'b1;
      pb_idx <= i[6:0];
      pb_data <= pat(i);
    end
    @(posedge mclk);
    pb_wr <= 1'b0;
  endtask

  // Follows array writes until done or the cycle bound runs out
  task automatic run_op(input logic [16:0] first, input logic is_prog,
                        input int max, input bit need_done, output int n);
    bit fin;
    n = 0;
    fin = 0;
    for (int i = 0; i < max && !fin; i++) begin
      @(posedge mclk);
      #1;
      if (i == 0) chk(busy, 1);
      if (arr_wr === 1'b1) begin
        chk(arr_addr, first + n);
        chk(arr_wdata, is_prog ? pat(n) : 8'hff);
        n++;
      end
      fin = (done === 1'b1);
    end
    if (need_done && !fin) begin
      n_mismatch++;
      complete_run();
    end
  endtask

  task automatic t_user();
    do_reset(3'h2, 1'b0);
    chk(flash_mode, FMEC_USER);
    request(1'b1, 1'b0, 4'h0, 17'h00000);
    expect_refused();
    request(1'b0, 1'b0, 4'h0, 17'h00000);
    expect_refused();
  endtask

  task automatic t_prog();
    int n;
    do_reset(3'h2, 1'b1);
    chk(flash_mode, FMEC_USER_PROG);
    load_page();
    request(1'b1, 1'b0, 4'h0, 17'h00080);
    run_op(17'h00080, 1'b1, 200, 1, n);
    chk(n, 128);
    request(1'b1, 1'b0, 4'h0, 17'h00140);
    expect_refused();
    request(1'b1, 1'b0, 4'h0, 17'h00101);
    expect_refused();
  endtask

  task automatic t_blocks();
    int sel [7] = '{0, 1, 2, 3, 4, 5, 9};
    int first;
    int n;
    foreach (sel[k]) begin
      first = 0;
      for (int j = 0; j < sel[k]; j++) first += blk_size[j];
      request(1'b0, 1'b0, sel[k][3:0], 17'h00000);
      run_op(first[16:0], 1'b0, 33000, 1, n);
      chk(n, blk_size[sel[k]]);
    end
    request(1'b0, 1'b0, 4'ha, 17'h00000);
    expect_refused();
  endtask

  task automatic t_boot();
    int n;
    bit fin;
    do_reset(3'h3, 1'b1);
    chk(flash_mode, FMEC_BOOT);
    chk(loader_active, 1);
    request(1'b0, 1'b0, 4'h2, 17'h00000);
    expect_refused();
    @(posedge mclk);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    n = 0;
    fin = 0;
    for (int i = 0; i < 4000 && !fin; i++) begin
      @(posedge mclk);
      #1;
      if (ram_wr === 1'b1) begin
        chk(ram_addr, n);
        chk(ram_wdata, PAYLOAD[8*n +: 8]);
        n++;
      end
      fin = (boot_done === 1'b1);
    end
    chk(n, 3);
    chk(fin, 1);
    if (!fin) complete_run();
    chk(ack_low >= 9 * BIT_CYC - BIT_CYC / 2 &&
        ack_low <= 9 * BIT_CYC + BIT_CYC / 2, 1);
    request(1'b0, 1'b1, 4'h0, 17'h00000);
    run_op(17'h00000, 1'b0, 16, 0, n);
    chk(n, 16);
  endtask

  task automatic t_programmer();
    int n;
    do_reset(3'h0, 1'b1);
    chk(flash_mode, FMEC_PROGRAMMER);
    load_page();
    request(1'b1, 1'b0, 4'h0, 17'h1ff80);
    run_op(17'h1ff80, 1'b1, 200, 1, n);
    chk(n, 128);
  endtask

  task automatic t_protect();
    do_reset(3'h3, 1'b0);
    chk(flash_mode, FMEC_USER);
    request(1'b0, 1'b1, 4'h0, 17'h00000);
    expect_refused();
  endtask

  initial begin
    reset_n = 1'b0;
    md_pin = 3'h2;
    program_erase_protect_pin = 1'b0;
    go = 1'b0;
    pb_wr = 1'b0;
    pb_idx = '0;
    pb_data = '0;
    prog_req = 1'b0;
    prog_addr = '0;
    erase_req = 1'b0;
    erase_all = 1'b0;
    erase_blk = '0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (2) @(posedge mclk);
    t_user();
    t_prog();
    t_blocks();
    t_boot();
    t_programmer();
    t_protect();
    complete_run();
  end
endmodule
`default_nettype wire
